// file: hw/scsc_top.v
// System clock switch controller with a classic Wishbone register slave.
`timescale 1ns/1ps
`include "scsc_regs.vh"

module scsc_top #(
    parameter OST_EDGES = `SCSC_OST_EDGES
) (
    // Clock and synchronous reset.
    input wire clk,
    input wire rst,
    // Wishbone slave.
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_we_i,
    input wire [7:0] wb_adr_i,
    input wire [3:0] wb_sel_i,
    input wire [31:0] wb_dat_i,
    output reg [31:0] wb_dat_o,
    output reg wb_ack_o,
    // Configuration levels from the device fuses.
    input wire switch_monitor_cfg,
    input wire [1:0] primary_submode_cfg,
    input wire [2:0] initial_source_cfg,
    input wire watchdog_en,
    // Oscillator clocks, multiplier status and clock failure from the analog side.
    input wire [3:0] osc_clk_in,
    input wire pll_clk_in,
    input wire pll_lock_in,
    input wire clk_fail_in,
    // Oscillator and multiplier control.
    output reg [3:0] osc_enable,
    output reg pll_enable,
    output reg [2:0] sys_clk_sel,
    output reg switch_busy,
    output reg irq
);

    localparam ST_IDLE = 3'h0;
    localparam ST_CHECK = 3'h1;
    localparam ST_OST = 3'h2;
    localparam ST_LOCK = 3'h3;
    localparam ST_SETTLE = 3'h4;
    localparam ST_SWAP = 3'h5;

    // Oscillator that a source code runs from.
    function [1:0] osc_of;
        input [2:0] src;
        begin
            case (src)
                `SCSC_SRC_PRI, `SCSC_SRC_PRI_PLL: osc_of = `SCSC_OSC_PRI;
                `SCSC_SRC_LPX: osc_of = `SCSC_OSC_LPX;
                `SCSC_SRC_SLOW_INTERNAL_RC: osc_of = `SCSC_OSC_SLOW_INTERNAL_RC;
                default: osc_of = `SCSC_OSC_FRC;
            endcase
        end
    endfunction

    // Whether a source code uses the multiplier.
    function uses_pll;
        input [2:0] src;
        begin
            uses_pll = (src == `SCSC_SRC_FRC_PLL) || (src == `SCSC_SRC_PRI_PLL);
        end
    endfunction

    // Whether a source needs the start-up timer; an external primary clock does not.
    function is_crystal;
        input [2:0] src;
        input [1:0] sub;
        begin
            is_crystal = (src == `SCSC_SRC_LPX) ||
                ((osc_of(src) == `SCSC_OSC_PRI) && (sub != `SCSC_SUB_EXT));
        end
    endfunction

    // Two-stage synchronisers; reset to idle levels so no false clock edge, lock or failure follows reset.
    reg [10:0] sync1;
    reg [10:0] sync2;
    always @(posedge clk)
    begin
        if (rst)
        begin
            sync1 <= 11'h400;
            sync2 <= 11'h400;
        end
        else
        begin
            sync1 <= {switch_monitor_cfg, watchdog_en, clk_fail_in, pll_lock_in, pll_clk_in, osc_clk_in, primary_submode_cfg};
            sync2 <= sync1;
        end
    end
    wire cfg_disable = sync2[10];
    wire wdt_on = sync2[9];
    wire fail_s = sync2[8];
    wire lock_s = sync2[7];
    wire pll_clk_s = sync2[6];
    wire [3:0] osc_s = sync2[5:2];
    wire [1:0] submode = sync2[1:0];
    wire sw_en = ~cfg_disable;

    // Initial source is caught once the synchronisers have filled after reset.
    reg [2:0] init_sync1;
    reg [2:0] init_sync2;
    reg [1:0] init_wait;
    always @(posedge clk)
    begin
        if (rst)
        begin
            init_sync1 <= 3'h0;
            init_sync2 <= 3'h0;
            init_wait <= 2'h0;
        end
        else
        begin
            init_sync1 <= initial_source_cfg;
            init_sync2 <= init_sync1;
            if (init_wait != 2'h3)
                init_wait <= init_wait + 2'h1;
        end
    end
    wire init_ready = (init_wait == 2'h3);

    // Software-visible state.
    reg [2:0] cur_src;
    reg [2:0] next_src;
    reg [2:0] tgt_src;
    reg req;
    reg lock_flag;
    reg fail_flag;
    reg arm_hi;
    reg arm_lo;
    reg key_hi_a;
    reg key_lo_a;
    reg [`SCSC_IRQ_W-1:0] irq_status;
    reg [`SCSC_IRQ_W-1:0] irq_mask;
    reg [2:0] state;
    reg [10:0] edge_cnt;
    reg new_clk_d;

    // Clock being brought up: the multiplier for a multiplier source once its start-up timer is done, otherwise the oscillator itself.
    wire new_clk_s = (uses_pll(tgt_src) && (state != ST_OST)) ? pll_clk_s : osc_s[osc_of(tgt_src)];
    wire new_edge = new_clk_s & ~new_clk_d;

    // Bus decode; each access is answered one cycle after it is seen.
    wire bus_req = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire wr = bus_req & wb_we_i;
    wire wr_ctrl = wr && (wb_adr_i == `SCSC_ADDR_CTRL);
    wire wr_key = wr && (wb_adr_i == `SCSC_ADDR_UNLOCK) && wb_sel_i[0];
    wire hi_ok = wr_ctrl & wb_sel_i[1] & arm_hi;
    wire lo_ok = wr_ctrl & wb_sel_i[0] & arm_lo;
    wire rejected = wr_ctrl & ((wb_sel_i[1] & ~arm_hi) | (wb_sel_i[0] & ~arm_lo));
    wire [7:0] key = wb_dat_i[7:0];

    // Events for the interrupt status.
    wire ev_abort = (state == ST_CHECK) && (next_src == cur_src);
    wire ev_done = (state == ST_SWAP);
    wire ev_fail = sw_en & fail_s & ~fail_flag;
    wire [`SCSC_IRQ_W-1:0] events;
    assign events = {ev_fail, rejected, ev_abort, ev_done};

    // Unlock sequencer: a matching key pair arms one byte for a single write.
    always @(posedge clk)
    begin
        if (rst)
        begin
            key_hi_a <= 1'b0;
            key_lo_a <= 1'b0;
            arm_hi <= 1'b0;
            arm_lo <= 1'b0;
        end
        else
        begin
            if (wr_key)
            begin
                key_hi_a <= (key == `SCSC_KEY_HI_A);
                key_lo_a <= (key == `SCSC_KEY_LO_A);
            end
            if (wr_key && key_hi_a && (key == `SCSC_KEY_HI_B))
                arm_hi <= 1'b1;
            else if (wr_ctrl && wb_sel_i[1])
                arm_hi <= 1'b0;
            if (wr_key && key_lo_a && (key == `SCSC_KEY_LO_B))
                arm_lo <= 1'b1;
            else if (wr_ctrl && wb_sel_i[0])
                arm_lo <= 1'b0;
        end
    end

    // Switch sequencer; the bus stays live throughout so the processor keeps running.
    always @(posedge clk)
    begin
        if (rst)
        begin
            state <= ST_IDLE;
            cur_src <= `SCSC_SRC_FRC;
            next_src <= `SCSC_SRC_FRC;
            tgt_src <= `SCSC_SRC_FRC;
            req <= 1'b0;
            lock_flag <= 1'b0;
            fail_flag <= 1'b0;
            edge_cnt <= 11'h0;
            new_clk_d <= 1'b0;
        end
        else
        begin
            new_clk_d <= new_clk_s;
            if (hi_ok)
                next_src <= wb_dat_i[`SCSC_NEXT_HI:`SCSC_NEXT_LO];
            if (ev_fail)
                fail_flag <= 1'b1;
            else if (lo_ok && !wb_dat_i[`SCSC_FAIL_BIT])
                fail_flag <= 1'b0;
            if (!sw_en)
            begin
                cur_src <= init_sync2;
                req <= 1'b0;
                state <= ST_IDLE;
            end
            else
            begin
                if (!init_ready)
                    cur_src <= init_sync2;
                case (state)
                    ST_IDLE:
                    begin
                        if (lo_ok && wb_dat_i[`SCSC_REQ_BIT] && init_ready)
                        begin
                            req <= 1'b1;
                            state <= ST_CHECK;
                        end
                    end
                    ST_CHECK:
                    begin
                        if (next_src == cur_src)
                        begin
                            req <= 1'b0;
                            state <= ST_IDLE;
                        end
                        else
                        begin
                            tgt_src <= next_src;
                            lock_flag <= 1'b0;
                            fail_flag <= 1'b0;
                            edge_cnt <= 11'h0;
                            new_clk_d <= 1'b1; // A stale level of the old target must not count as an edge.
                            if (is_crystal(next_src, submode))
                                state <= ST_OST;
                            else
                                state <= ST_LOCK;
                        end
                    end
                    ST_OST:
                    begin
                        if (new_edge)
                            edge_cnt <= edge_cnt + 11'h1;
                        if (edge_cnt >= OST_EDGES[10:0])
                        begin
                            edge_cnt <= 11'h0;
                            state <= ST_LOCK;
                        end
                    end
                    ST_LOCK:
                    begin
                        if (!uses_pll(tgt_src) || lock_s)
                        begin
                            lock_flag <= uses_pll(tgt_src);
                            edge_cnt <= 11'h0;
                            state <= ST_SETTLE;
                        end
                    end
                    ST_SETTLE:
                    begin
                        if (new_edge)
                            edge_cnt <= edge_cnt + 11'h1;
                        if (edge_cnt == {7'h0, `SCSC_SETTLE_EDGES})
                            state <= ST_SWAP;
                    end
                    ST_SWAP:
                    begin
                        cur_src <= tgt_src;
                        req <= 1'b0;
                        state <= ST_IDLE;
                    end
                    default:
                        state <= ST_IDLE;
                endcase
            end
        end
    end

    // Interrupt status is sticky with write-one-to-clear; a new event beats a clear.
    always @(posedge clk)
    begin
        if (rst)
        begin
            irq_status <= {`SCSC_IRQ_W{1'b0}};
            irq_mask <= {`SCSC_IRQ_W{1'b0}};
            irq <= 1'b0;
        end
        else
        begin
            if (wr && (wb_adr_i == `SCSC_ADDR_IRQ_STATUS) && wb_sel_i[0])
                irq_status <= (irq_status & ~wb_dat_i[`SCSC_IRQ_W-1:0]) | events;
            else
                irq_status <= irq_status | events;
            if (wr && (wb_adr_i == `SCSC_ADDR_IRQ_MASK) && wb_sel_i[0])
                irq_mask <= wb_dat_i[`SCSC_IRQ_W-1:0];
            irq <= |(irq_status & irq_mask);
        end
    end

    // Oscillator enables: current source plus the one being brought up; slow RC kept for watchdog/monitor.
    always @(posedge clk)
    begin
        if (rst)
        begin
            osc_enable <= 4'h0;
            pll_enable <= 1'b0;
            sys_clk_sel <= `SCSC_SRC_FRC;
            switch_busy <= 1'b0;
        end
        else
        begin
            osc_enable <= (4'h1 << osc_of(cur_src)) |
                ((state >= ST_OST) ? (4'h1 << osc_of(tgt_src)) : 4'h0) |
                (((wdt_on | sw_en) ? 4'h1 : 4'h0) << `SCSC_OSC_SLOW_INTERNAL_RC);
            pll_enable <= uses_pll(cur_src) | ((state >= ST_OST) & uses_pll(tgt_src));
            sys_clk_sel <= cur_src;
            switch_busy <= (state != ST_IDLE);
        end
    end

    // Read mux and acknowledge; unmapped addresses are acknowledged and read zero.
    always @(posedge clk)
    begin
        if (rst)
        begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0;
        end
        else
        begin
            wb_ack_o <= bus_req;
            wb_dat_o <= 32'h0;
            if (bus_req && !wb_we_i)
            begin
                case (wb_adr_i)
                    `SCSC_ADDR_CTRL:
                    begin
                        wb_dat_o[`SCSC_CUR_HI:`SCSC_CUR_LO] <= cur_src;
                        wb_dat_o[`SCSC_NEXT_HI:`SCSC_NEXT_LO] <= next_src;
                        wb_dat_o[`SCSC_LOCK_BIT] <= lock_flag;
                        wb_dat_o[`SCSC_FAIL_BIT] <= fail_flag;
                        wb_dat_o[`SCSC_REQ_BIT] <= req & sw_en;
                    end
                    `SCSC_ADDR_IRQ_STATUS: wb_dat_o[`SCSC_IRQ_W-1:0] <= irq_status;
                    `SCSC_ADDR_IRQ_MASK: wb_dat_o[`SCSC_IRQ_W-1:0] <= irq_mask;
                    `SCSC_ADDR_CONFIG: wb_dat_o[6:0] <= {state, submode, arm_hi, sw_en};
                    default: wb_dat_o <= 32'h0;
                endcase
            end
        end
    end

endmodule // scsc_top

// file: pkg/scsc_regs.vh
// Register map, field positions, source codes and timing constants of the clock switch controller.
// Overview of operation
// - Software may select the primary, low-power crystal, fast RC or slow RC source whenever no switch is in progress.
// - Primary submode comes from a configuration field; switching never changes it.
// - Switching and fail-safe monitor work only while the monitor configuration bit is 0.
// - With switching disabled, next-source is ignored and current-source shows the initial source.
// - With switching disabled, the switch request bit does nothing and reads 0.
// - A request whose next-source equals current-source is cleared and aborted.
// - A valid switch clears the lock status bit and the clock fail flag.
// - The new oscillator is enabled; crystal sources wait for the start-up timer.
// - Sources using the multiplier wait until the lock status bit reads 1.
// - Ten cycles of the new clock are counted before the changeover.
// - Changeover clears the switch request and copies next-source into current-source.
// - The old source is then disabled, except slow RC while watchdog or monitor runs.
// - The processor keeps running during a switch; the bus stays served throughout.
`ifndef SCSC_REGS_VH
`define SCSC_REGS_VH

// Register byte offsets on the bus.
`define SCSC_ADDR_CTRL 8'h00
`define SCSC_ADDR_UNLOCK 8'h04
`define SCSC_ADDR_IRQ_STATUS 8'h08
`define SCSC_ADDR_IRQ_MASK 8'h0C
`define SCSC_ADDR_CONFIG 8'h10

// Control register fields.
`define SCSC_CUR_HI 14
`define SCSC_CUR_LO 12
`define SCSC_NEXT_HI 10
`define SCSC_NEXT_LO 8
`define SCSC_LOCK_BIT 5
`define SCSC_FAIL_BIT 3
`define SCSC_REQ_BIT 0

// Unlock keys: two writes in a row arm one byte of the control register.
`define SCSC_KEY_HI_A 8'h57
`define SCSC_KEY_HI_B 8'hA8
`define SCSC_KEY_LO_A 8'h46
`define SCSC_KEY_LO_B 8'hB9

// Interrupt status and mask bits.
`define SCSC_IRQ_DONE 0
`define SCSC_IRQ_ABORT 1
`define SCSC_IRQ_REJECT 2
`define SCSC_IRQ_FAIL 3
`define SCSC_IRQ_W 4

// Source codes.
`define SCSC_SRC_FRC 3'h0
`define SCSC_SRC_FRC_PLL 3'h1
`define SCSC_SRC_PRI 3'h2
`define SCSC_SRC_PRI_PLL 3'h3
`define SCSC_SRC_LPX 3'h4
`define SCSC_SRC_SLOW_INTERNAL_RC 3'h5

// Oscillator enable indices.
`define SCSC_OSC_PRI 2'h0
`define SCSC_OSC_LPX 2'h1
`define SCSC_OSC_FRC 2'h2
`define SCSC_OSC_SLOW_INTERNAL_RC 2'h3

// Primary submode codes.
`define SCSC_SUB_EXT 2'h0
`define SCSC_SUB_STD 2'h1
`define SCSC_SUB_HS 2'h2

// Edges of the new clock counted before changeover.
`define SCSC_SETTLE_EDGES 4'hA
// Start-up timer length in edges of the crystal clock.
`define SCSC_OST_EDGES 1024

`endif

// file: verif/scsc_top_properties.sv
// Concurrent checks on the ports of the clock switch controller.
`timescale 1ns/1ps
module scsc_top_properties #(
    parameter OST_EDGES = 1024
) (
    // Clock and reset.
    input wire clk,
    input wire rst,
    // Bus handshake.
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire [31:0] wb_dat_o,
    input wire wb_ack_o,
    // Configuration and oscillator control.
    input wire switch_monitor_cfg,
    input wire [2:0] initial_source_cfg,
    input wire [3:0] osc_enable,
    input wire pll_enable,
    input wire [2:0] sys_clk_sel,
    input wire switch_busy
);
    reg [3:0] up_cnt;

    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    // Oscillator index used by a source code.
    function [1:0] osc_of(input [2:0] s);
        osc_of = (s < 3'h2) ? 2'h2 : (s < 3'h4) ? 2'h0 : (s == 3'h4) ? 2'h1 : 2'h3;
    endfunction

    // Cycles since reset release; the synchronisers need a few before outputs mean anything.
    always @(posedge clk)
    begin
        if (rst)
            up_cnt <= 4'h0;
        else if (up_cnt != 4'hF)
            up_cnt <= up_cnt + 4'h1;
    end

    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack longer than one cycle");
    a_ack_next_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus request not answered next cycle");
    a_data_zero_idle: assert property (!wb_ack_o |-> wb_dat_o == 32'h0) else $error("read data without ack");
    a_disabled_no_switch: assert property (switch_monitor_cfg [*4] |-> !switch_busy)
        else $error("switch started while disabled");
    a_disabled_init_sel: assert property (switch_monitor_cfg && up_cnt == 4'hF |-> sys_clk_sel == initial_source_cfg)
        else $error("selection differs from initial source");
    a_selected_osc_on: assert property ((!switch_busy) [*3] ##0 (!switch_monitor_cfg && up_cnt == 4'hF)
        |-> osc_enable[osc_of(sys_clk_sel)]) else $error("selected oscillator is off");
    a_pll_with_mult: assert property ((!switch_busy) [*3] ##0
        (up_cnt == 4'hF && sys_clk_sel[0] && sys_clk_sel < 3'h4) |-> pll_enable)
        else $error("multiplier off for a multiplier source");
    a_sel_needs_switch: assert property (!switch_monitor_cfg && up_cnt == 4'hF && $changed(sys_clk_sel)
        |-> $past(switch_busy) || $past(switch_busy, 2)) else $error("selection changed outside a switch");
    a_slow_rc_kept: assert property (!switch_monitor_cfg && up_cnt == 4'hF |-> osc_enable[3])
        else $error("slow RC turned off while monitor enabled");

    c_switch_run: cover property ($fell(switch_busy));
    c_mult_source: cover property (pll_enable && sys_clk_sel == 3'h3);
    c_disabled: cover property (switch_monitor_cfg && up_cnt == 4'hF);
endmodule // scsc_top_properties

bind scsc_top scsc_top_properties #(.OST_EDGES(OST_EDGES)) u_props (.clk(clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .switch_monitor_cfg(switch_monitor_cfg),
    .initial_source_cfg(initial_source_cfg), .osc_enable(osc_enable), .pll_enable(pll_enable),
    .sys_clk_sel(sys_clk_sel), .switch_busy(switch_busy));

// file: verif/system_clock_switch_controller_tb_top.sv
// Self-checking bench for the clock switch controller.
`timescale 1ns/1ps
`include "scsc_regs.vh"
module system_clock_switch_controller_tb_top;
    reg clk, rst, cyc, stb, we, mon, wdog, lock, cfail, pllc;
    reg [7:0] adr;
    reg [3:0] sel_b, run, cnt, osc;
    reg [31:0] wdat, rd;
    reg [2:0] init_src;
    reg [1:0] sub;
    wire [31:0] rdat;
    wire ack, busy, pll_en, irq;
    wire [3:0] osc_en;
    wire [2:0] sel;
    integer fail_count, compares;

    scsc_top #(.OST_EDGES(8)) i_dut (.clk(clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel_b), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack),
        .switch_monitor_cfg(mon), .primary_submode_cfg(sub), .initial_source_cfg(init_src), .watchdog_en(wdog),
        .osc_clk_in(osc), .pll_clk_in(pllc), .pll_lock_in(lock), .clk_fail_in(cfail), .osc_enable(osc_en),
        .pll_enable(pll_en), .sys_clk_sel(sel), .switch_busy(busy), .irq(irq));

    initial
    begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end

    // Oscillators run at one eighth of clk, only while enabled, so a stalled source really stalls.
    always @(posedge clk)
    begin
        cnt <= rst ? 4'h0 : cnt + 4'h1;
        osc <= {4{cnt[2]}} & run & osc_en;
        pllc <= cnt[2] & pll_en;
    end

    function [1:0] oi(input [2:0] s);
        oi = (s < 3'h2) ? 2'h2 : (s < 3'h4) ? 2'h0 : (s == 3'h4) ? 2'h1 : 2'h3;
    endfunction

    task wrap_up;
    begin
        if (fail_count == 0 && compares > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    end
    endtask

    task chk(input [31:0] got, input [31:0] exp);
    begin
        compares = compares + 1;
        if (got !== exp)
        begin
            fail_count = fail_count + 1;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    end
    endtask

    task stop(input [8*8-1:0] what);
    begin
        fail_count = fail_count + 1;
        $display("ERROR %0t timeout %0s", $time, what);
        wrap_up;
    end
    endtask

    // One classic Wishbone cycle; read data is taken at the edge that samples ack.
    task bus(input w, input [7:0] a, input [31:0] d, input [3:0] s);
        integer n;
    begin
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        sel_b <= s;
        @(posedge clk);
        while (ack !== 1'b1 && n < 50)
        begin
            n = n + 1;
            @(posedge clk);
        end
        if (n == 50)
            stop("bus");
        rd = rdat;
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk);
    end
    endtask

    // Full unlock-and-request sequence; bit 3 written as one leaves the clock fail flag to the hardware.
    task sw(input [2:0] s);
    begin
        bus(1, `SCSC_ADDR_UNLOCK, {24'h0, `SCSC_KEY_HI_A}, 4'h1);
        bus(1, `SCSC_ADDR_UNLOCK, {24'h0, `SCSC_KEY_HI_B}, 4'h1);
        bus(1, `SCSC_ADDR_CTRL, {21'h0, s, 8'h0}, 4'h2);
        bus(1, `SCSC_ADDR_UNLOCK, {24'h0, `SCSC_KEY_LO_A}, 4'h1);
        bus(1, `SCSC_ADDR_UNLOCK, {24'h0, `SCSC_KEY_LO_B}, 4'h1);
        bus(1, `SCSC_ADDR_CTRL, 32'h9, 4'h1);
    end
    endtask

    task wait_idle;
        integer n;
    begin
        n = 0;
        while (busy !== 1'b0 && n < 3000)
        begin
            n = n + 1;
            @(posedge clk);
        end
        if (n == 3000)
            stop("switch");
        repeat (3) @(posedge clk);
    end
    endtask

    // Outcome of a finished switch from source p to source s.
    task post(input [2:0] s, input [2:0] p);
    begin
        bus(0, `SCSC_ADDR_CTRL, 32'h0, 4'hF);
        chk(rd[14:12], s);
        chk(rd[0], 0);
        chk(sel, s);
        chk(osc_en[oi(s)], 1);
        if (oi(p) != oi(s) && oi(p) != 2'h3)
            chk(osc_en[oi(p)], 0);
        chk(osc_en[3], 1);
    end
    endtask

    initial
    begin
        {cyc, stb, we, wdog, lock, cfail, mon} = 7'h0;
        {adr, sel_b, wdat, rd, init_src} = 0;
        rst = 1'b1;
        sub = `SCSC_SUB_STD;
        run = 4'hF;
        fail_count = 0;
        compares = 0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (6) @(posedge clk);
        bus(0, `SCSC_ADDR_CONFIG, 32'h0, 4'hF);
        chk(rd[6:0], 7'h05);
        // Unarmed write is refused; its event stays masked until the mask is opened.
        bus(1, `SCSC_ADDR_CTRL, 32'h500, 4'h2);
        bus(0, `SCSC_ADDR_CTRL, 32'h0, 4'hF);
        chk(rd[10:8], 0);
        chk(irq, 0);
        bus(1, `SCSC_ADDR_IRQ_MASK, 32'h4, 4'hF);
        chk(irq, 1);
        bus(1, `SCSC_ADDR_IRQ_STATUS, 32'hF, 4'hF);
        @(posedge clk);
        chk(irq, 0);
        bus(0, 8'h20, 32'h0, 4'hF);
        chk(rd, 0);
        // Redundant request is dropped, and the arm it used cannot be reused.
        sw(`SCSC_SRC_FRC);
        wait_idle;
        post(`SCSC_SRC_FRC, `SCSC_SRC_FRC);
        bus(1, `SCSC_ADDR_CTRL, 32'h500, 4'h2);
        bus(0, `SCSC_ADDR_CTRL, 32'h0, 4'hF);
        chk(rd[10:8], 0);
        bus(0, `SCSC_ADDR_IRQ_STATUS, 32'h0, 4'hF);
        chk(rd[1], 1);
        chk(rd[2], 1);
        // A clock failure flag is wiped by the hardware when a real switch begins.
        cfail <= 1'b1;
        repeat (4) @(posedge clk);
        cfail <= 1'b0;
        bus(0, `SCSC_ADDR_CTRL, 32'h0, 4'hF);
        chk(rd[3], 1);
        sw(`SCSC_SRC_PRI);
        bus(0, `SCSC_ADDR_CTRL, 32'h0, 4'hF);
        chk(rd[3], 0);
        wait_idle;
        post(`SCSC_SRC_PRI, `SCSC_SRC_FRC);
        // Multiplier source holds off until lock is seen.
        sw(`SCSC_SRC_PRI_PLL);
        repeat (100) @(posedge clk);
        chk(busy, 1);
        chk(sel, `SCSC_SRC_PRI);
        lock <= 1'b1;
        wait_idle;
        post(`SCSC_SRC_PRI_PLL, `SCSC_SRC_PRI);
        chk(rd[5], 1);
        chk(pll_en, 1);
        // Slow RC with its clock stalled: no changeover without new-clock edges.
        run <= 4'h7;
        sw(`SCSC_SRC_SLOW_INTERNAL_RC);
        bus(0, `SCSC_ADDR_CTRL, 32'h0, 4'hF);
        chk(rd[5], 0);
        repeat (100) @(posedge clk);
        chk(busy, 1);
        run <= 4'hF;
        wait_idle;
        post(`SCSC_SRC_SLOW_INTERNAL_RC, `SCSC_SRC_PRI_PLL);
        chk(pll_en, 0);
        sw(`SCSC_SRC_LPX);
        wait_idle;
        post(`SCSC_SRC_LPX, `SCSC_SRC_SLOW_INTERNAL_RC);
        sw(`SCSC_SRC_FRC);
        wait_idle;
        post(`SCSC_SRC_FRC, `SCSC_SRC_LPX);
        sw(`SCSC_SRC_FRC_PLL);
        wait_idle;
        post(`SCSC_SRC_FRC_PLL, `SCSC_SRC_FRC);
        chk(rd[5], 1);
        chk(pll_en, 1);
        bus(0, `SCSC_ADDR_IRQ_STATUS, 32'h0, 4'hF);
        chk(rd[0], 1);
        // Second reset with switching disabled; only the watchdog then keeps slow RC running.
        mon <= 1'b1;
        wdog <= 1'b1;
        sub <= `SCSC_SUB_HS;
        init_src <= `SCSC_SRC_LPX;
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        sw(`SCSC_SRC_SLOW_INTERNAL_RC);
        repeat (20) @(posedge clk);
        bus(0, `SCSC_ADDR_CTRL, 32'h0, 4'hF);
        chk(rd[14:12], `SCSC_SRC_LPX);
        chk(sel, `SCSC_SRC_LPX);
        chk(rd[0], 0);
        chk(busy, 0);
        bus(0, `SCSC_ADDR_CONFIG, 32'h0, 4'hF);
        chk(rd[6:0], 7'h08);
        chk(osc_en, 4'hA);
        wdog <= 1'b0;
        repeat (4) @(posedge clk);
        chk(osc_en, 4'h2);
        wrap_up;
    end
endmodule // system_clock_switch_controller_tb_top
